// ===== verilog/imsc_regs.vh
// constants for the interrupt mask and sequence control block
// assumes 16-bit registers reached over a 24-bit serial frame
`ifndef IMSC_REGS_VH
`define IMSC_REGS_VH

// ****************************************************************
// register addresses (6-bit)
// ****************************************************************
`define IMSC_ADDR_IEN     6'h05
`define IMSC_ADDR_CTLA    6'h06
`define IMSC_ADDR_STAT    6'h3e

// ****************************************************************
// interrupt enable register fields
// ****************************************************************
`define IMSC_IEN_ATTN     15
`define IMSC_IEN_RAMADDR  12
`define IMSC_IEN_ARBBUSY  11
`define IMSC_IEN_PLL      9
`define IMSC_IEN_DEEPDOZE 8
`define IMSC_IEN_DOZE     4
`define IMSC_IEN_CMP2     1
`define IMSC_IEN_CMP1     0
`define IMSC_IEN_RESET    16'h8000
`define IMSC_IEN_WMASK    16'h9b13

// ****************************************************************
// primary control register fields
// ****************************************************************
`define IMSC_CTLA_CCA     10
`define IMSC_CTLA_TXDONE  9
`define IMSC_CTLA_RXDONE  8
`define IMSC_CTLA_TRIG    7
`define IMSC_CTLA_TYPE_HI 5
`define IMSC_CTLA_TYPE_LO 4
`define IMSC_CTLA_SEQ_HI  1
`define IMSC_CTLA_SEQ_LO  0
`define IMSC_CTLA_RESET   16'h0000
`define IMSC_CTLA_WMASK   16'h07b3

// ****************************************************************
// pending status layout and codes
// ****************************************************************
`define IMSC_ST_ATTN      15
`define IMSC_ST_RAMADDR   12
`define IMSC_ST_ARBBUSY   11
`define IMSC_ST_CCA       10
`define IMSC_ST_PLL       9
`define IMSC_ST_RXDONE    8
`define IMSC_ST_TXDONE    7
`define IMSC_ST_DOZE      4
`define IMSC_ST_CMP2      1
`define IMSC_ST_CMP1      0
`define IMSC_SEQ_IDLE     2'h0
`define IMSC_SEQ_ASSESS   2'h1
`define IMSC_SEQ_RX       2'h2
`define IMSC_SEQ_TX       2'h3
`define IMSC_TYPE_CCA     2'h1
`define IMSC_TYPE_ED      2'h2

// ****************************************************************
// serial frame counts
// ****************************************************************
`define IMSC_HDR_LAST     5'h07
`define IMSC_DATA_FIRST   5'h08
`define IMSC_FRAME_LAST   5'h17
`define IMSC_FRAME_BITS   5'h18

`endif

// ===== verilog/imsc_spi_slave.v
// serial register port: header byte then one 16-bit data word
// assumes all pins synchronous to clk and sclk slower than clk/6
`include "imsc_regs.vh"

module imsc_spi_slave (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        ce_n,
    input  wire        sclk,
    input  wire        mosi,
    output wire        miso,
    output wire        miso_oe,
    output reg         hdr_valid,
    output reg         hdr_read,
    output reg  [5:0]  hdr_addr,
    input  wire [15:0] rd_data,
    output reg         wr_valid,
    output reg  [15:0] wr_data
);

    reg        sclk_q;   // previous clock level for edge finding
    reg [4:0]  bit_cnt;  // bits taken in this frame
    reg [15:0] rx_sh;    // incoming shift register
    reg [15:0] tx_sh;    // outgoing shift register

    wire rise = ~ce_n & sclk & ~sclk_q;
    wire fall = ~ce_n & ~sclk & sclk_q;

    assign miso    = tx_sh[15];
    assign miso_oe = ~ce_n;

    // ************************************************************
    // frame engine
    // ************************************************************
    // mode 0: sample on rising edge, shift out on falling edge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q    <= 1'b0;
            bit_cnt   <= 5'h00;
            rx_sh     <= 16'h0000;
            tx_sh     <= 16'h0000;
            hdr_valid <= 1'b0;
            hdr_read  <= 1'b0;
            hdr_addr  <= 6'h00;
            wr_valid  <= 1'b0;
            wr_data   <= 16'h0000;
        end else begin
            sclk_q    <= sclk;
            hdr_valid <= 1'b0;
            wr_valid  <= 1'b0;
            if (hdr_valid) begin
                // taken with the status clear: read sees the old flags
                tx_sh <= rd_data;
            end
            if (ce_n) begin
                // frame ends: drop any partial word
                bit_cnt <= 5'h00;
            end else if (rise && bit_cnt != `IMSC_FRAME_BITS) begin
                rx_sh   <= {rx_sh[14:0], mosi};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == `IMSC_HDR_LAST) begin
                    hdr_valid <= 1'b1;
                    hdr_read  <= rx_sh[6];
                    hdr_addr  <= {rx_sh[4:0], mosi};
                end
                if (bit_cnt == `IMSC_FRAME_LAST && !hdr_read) begin
                    wr_valid <= 1'b1;
                    wr_data  <= {rx_sh[14:0], mosi};
                end
            end else if (fall && bit_cnt > `IMSC_DATA_FIRST) begin
                // the first data bit stands from load to ninth rise
                tx_sh <= {tx_sh[14:0], 1'b0};
            end
        end
    end

endmodule

// ===== verilog/imsc_doze_ctl.v
// doze state keeper with normal and deep doze exits
// assumes doze_req is a level from the power control register
module imsc_doze_ctl (
    input  wire clk,
    input  wire arst_n,
    input  wire doze_req,
    input  wire deep_doze,
    input  wire cmp_two,
    input  wire attn_n,
    output reg  in_doze,
    output reg  timer_clk_en,
    output reg  attn_event
);

    reg doze_req_q;  // previous request level
    reg attn_n_q;    // previous attention pin level

    wire attn_fall = attn_n_q & ~attn_n;
    // deep doze ignores the comparator so timers may stop
    wire wake      = attn_fall | (~deep_doze & cmp_two);

    // ************************************************************
    // doze state
    // ************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            doze_req_q   <= 1'b0;
            attn_n_q     <= 1'b1;
            in_doze      <= 1'b0;
            timer_clk_en <= 1'b1;
            attn_event   <= 1'b0;
        end else begin
            doze_req_q <= doze_req;
            attn_n_q   <= attn_n;
            attn_event <= attn_fall;
            if (wake) begin
                // a wake in the entry cycle wins: no lost exit
                in_doze <= 1'b0;
            end else if (doze_req & ~doze_req_q) begin
                in_doze <= 1'b1;
            end
            timer_clk_en <= ~(in_doze & deep_doze);
        end
    end

endmodule

// ===== verilog/imsc_top.v
// interrupt masking and transceiver sequence control registers
// assumes event inputs are one-cycle pulses synchronous to CLK
//
// Contract
// - enabled true flag drives interrupt pin
// - reading status flag removes pending interrupt
// - attention enable bit 15 resets to one
// - bit 12 gates buffer address error
// - bit 11 gates arbiter busy error
// - bit 9 gates synthesizer unlock flag
// - deep doze waits for attention, timers stopped
// - normal doze exits on comparator or attention
// - bit 4 gates doze timer flag
// - bit 1 gates comparator two flag
// - bit 0 gates comparator one flag
// - control bit 10 gates assessment done
// - control bit 9 gates transmit done
// - control bit 8 gates packet received
// - timer trigger starts sequence on comparator two
// - manual start through enable pin otherwise
// - bits 5-4 pick clear channel or energy
// - bits 1-0 pick idle, assess, receive, transmit
`include "imsc_regs.vh"

module imsc_top (
    input  wire       CLK,
    input  wire       ARST_N,
    input  wire       CE_N,
    input  wire       SCLK,
    input  wire       MOSI,
    output wire       MISO,
    output wire       MISO_OE,
    output reg        IRQ_N,
    input  wire       RADIO_SEQUENCE_ENABLE_PIN,
    input  wire       ATTN_N,
    input  wire       COMPARATOR_TWO,
    input  wire       COMPARATOR_TWO_PRIMED,
    input  wire       COMPARATOR_ONE,
    input  wire       DOZE_REQUEST,
    input  wire       EV_RAM_ADDR_ERR,
    input  wire       EV_ARB_BUSY_ERR,
    input  wire       EV_PLL_UNLOCK,
    input  wire       EV_DOZE_TIMER,
    input  wire       EV_ASSESS_DONE,
    input  wire       EV_TX_DONE,
    input  wire       EV_RX_DONE,
    output reg        SEQ_START,
    output wire [1:0] SEQ_SELECT,
    output wire [1:0] ASSESS_TYPE,
    output wire       DOZE_ACTIVE,
    output wire       EVENT_TIMER_CLK_EN
);

    // ************************************************************
    // storage
    // ************************************************************
    reg  [15:0] interrupt_enable_reg;  // masks and deep doze
    reg  [15:0] primary_control_reg;   // masks, trigger, modes
    reg  [15:0] pending;               // sticky event flags
    reg  [15:0] next_pending;          // flags after set/clear
    reg  [15:0] rd_mux;                // read data for a header
    reg         seq_pin_q;             // previous enable pin level
    reg         start_req;             // sequence start condition
    reg  [15:0] enabled_mask;          // enables in status layout

    // serial port wiring
    wire        hdr_valid;
    wire        hdr_read;
    wire [5:0]  hdr_addr;
    wire        wr_valid;
    wire [15:0] wr_data;
    wire        attn_event;

    // clear strobe: the status word is captured for output on this same edge
    wire stat_read = hdr_valid & hdr_read &
                     (hdr_addr == `IMSC_ADDR_STAT);

    // ************************************************************
    // helpers
    // ************************************************************
    // keep reserved positions at reset, take writable bits
    function [15:0] merge_write;
        input [15:0] wmask;
        input [15:0] rst_val;
        input [15:0] data;
        begin
            merge_write = (data & wmask) | (rst_val & ~wmask);
        end
    endfunction

    // ************************************************************
    // serial register port
    // ************************************************************
    imsc_spi_slave u_spi (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .ce_n      (CE_N),
        .sclk      (SCLK),
        .mosi      (MOSI),
        .miso      (MISO),
        .miso_oe   (MISO_OE),
        .hdr_valid (hdr_valid),
        .hdr_read  (hdr_read),
        .hdr_addr  (hdr_addr),
        .rd_data   (rd_mux),
        .wr_valid  (wr_valid),
        .wr_data   (wr_data)
    );

    // ************************************************************
    // doze control
    // ************************************************************
    imsc_doze_ctl u_doze (
        .clk          (CLK),
        .arst_n       (ARST_N),
        .doze_req     (DOZE_REQUEST),
        .deep_doze    (interrupt_enable_reg[`IMSC_IEN_DEEPDOZE]),
        .cmp_two      (COMPARATOR_TWO),
        .attn_n       (ATTN_N),
        .in_doze      (DOZE_ACTIVE),
        .timer_clk_en (EVENT_TIMER_CLK_EN),
        .attn_event   (attn_event)
    );

    // ************************************************************
    // register writes
    // ************************************************************
    // unmapped writes are dropped; reserved bits never change
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            interrupt_enable_reg <= `IMSC_IEN_RESET;
            primary_control_reg  <= `IMSC_CTLA_RESET;
        end else if (wr_valid) begin
            if (hdr_addr == `IMSC_ADDR_IEN) begin
                interrupt_enable_reg <= merge_write(
                    `IMSC_IEN_WMASK, `IMSC_IEN_RESET,
                    wr_data);
            end
            if (hdr_addr == `IMSC_ADDR_CTLA) begin
                primary_control_reg <= merge_write(
                    `IMSC_CTLA_WMASK, `IMSC_CTLA_RESET,
                    wr_data);
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    // unmapped addresses read as zero
    always @* begin
        case (hdr_addr)
            `IMSC_ADDR_IEN:  rd_mux = interrupt_enable_reg;
            `IMSC_ADDR_CTLA: rd_mux = primary_control_reg;
            `IMSC_ADDR_STAT: rd_mux = pending;
            default:         rd_mux = 16'h0000;
        endcase
    end

    // ************************************************************
    // pending flags
    // ************************************************************
    // a set in the clear cycle survives: the read took the old word
    always @* begin
        next_pending = stat_read ? 16'h0000 : pending;
        next_pending[`IMSC_ST_ATTN]    =
            next_pending[`IMSC_ST_ATTN]    | attn_event;
        next_pending[`IMSC_ST_RAMADDR] =
            next_pending[`IMSC_ST_RAMADDR] | EV_RAM_ADDR_ERR;
        next_pending[`IMSC_ST_ARBBUSY] =
            next_pending[`IMSC_ST_ARBBUSY] | EV_ARB_BUSY_ERR;
        next_pending[`IMSC_ST_CCA]     =
            next_pending[`IMSC_ST_CCA]     | EV_ASSESS_DONE;
        next_pending[`IMSC_ST_PLL]     =
            next_pending[`IMSC_ST_PLL]     | EV_PLL_UNLOCK;
        next_pending[`IMSC_ST_RXDONE]  =
            next_pending[`IMSC_ST_RXDONE]  | EV_RX_DONE;
        next_pending[`IMSC_ST_TXDONE]  =
            next_pending[`IMSC_ST_TXDONE]  | EV_TX_DONE;
        next_pending[`IMSC_ST_DOZE]    =
            next_pending[`IMSC_ST_DOZE]    | EV_DOZE_TIMER;
        next_pending[`IMSC_ST_CMP2]    =
            next_pending[`IMSC_ST_CMP2]    | COMPARATOR_TWO;
        next_pending[`IMSC_ST_CMP1]    =
            next_pending[`IMSC_ST_CMP1]    | COMPARATOR_ONE;
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pending <= 16'h0000;
        end else begin
            pending <= next_pending;
        end
    end

    // ************************************************************
    // enable gathering into status layout
    // ************************************************************
    always @* begin
        enabled_mask = 16'h0000;
        enabled_mask[`IMSC_ST_ATTN]    =
            interrupt_enable_reg[`IMSC_IEN_ATTN];
        enabled_mask[`IMSC_ST_RAMADDR] =
            interrupt_enable_reg[`IMSC_IEN_RAMADDR];
        enabled_mask[`IMSC_ST_ARBBUSY] =
            interrupt_enable_reg[`IMSC_IEN_ARBBUSY];
        enabled_mask[`IMSC_ST_PLL]     =
            interrupt_enable_reg[`IMSC_IEN_PLL];
        enabled_mask[`IMSC_ST_DOZE]    =
            interrupt_enable_reg[`IMSC_IEN_DOZE];
        enabled_mask[`IMSC_ST_CMP2]    =
            interrupt_enable_reg[`IMSC_IEN_CMP2];
        enabled_mask[`IMSC_ST_CMP1]    =
            interrupt_enable_reg[`IMSC_IEN_CMP1];
        enabled_mask[`IMSC_ST_CCA]     =
            primary_control_reg[`IMSC_CTLA_CCA];
        enabled_mask[`IMSC_ST_TXDONE]  =
            primary_control_reg[`IMSC_CTLA_TXDONE];
        enabled_mask[`IMSC_ST_RXDONE]  =
            primary_control_reg[`IMSC_CTLA_RXDONE];
    end

    // ************************************************************
    // interrupt pin
    // ************************************************************
    // registered so the pin never glitches; one cycle behind flags
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IRQ_N <= 1'b1;
        end else begin
            IRQ_N <= ~|(pending & enabled_mask);
        end
    end

    // ************************************************************
    // sequence start
    // ************************************************************
    assign SEQ_SELECT  = primary_control_reg[`IMSC_CTLA_SEQ_HI:
                                             `IMSC_CTLA_SEQ_LO];
    assign ASSESS_TYPE = primary_control_reg[`IMSC_CTLA_TYPE_HI:
                                             `IMSC_CTLA_TYPE_LO];

    // idle selection never starts anything
    always @* begin
        if (SEQ_SELECT == `IMSC_SEQ_IDLE) begin
            start_req = 1'b0;
        end else if (primary_control_reg[`IMSC_CTLA_TRIG]) begin
            start_req = COMPARATOR_TWO |
                        COMPARATOR_TWO_PRIMED;
        end else begin
            start_req = RADIO_SEQUENCE_ENABLE_PIN & ~seq_pin_q;
        end
    end

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seq_pin_q <= 1'b0;
            SEQ_START <= 1'b0;
        end else begin
            seq_pin_q <= RADIO_SEQUENCE_ENABLE_PIN;
            SEQ_START <= start_req;
        end
    end

endmodule

// ===== testbench/imsc_host_model.sv
// host model: serial register master
// assumes a free-running clk; 4 clk per serial phase
module imsc_host_model (
    input  wire logic clk,
    output logic      ce_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;

    // serial clock low and enable high outside frames
    initial begin
        ce_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // ****************************
    // one frame: read flag, spare bit, 6-bit address, 16-bit data
    // ****************************
    // half period of 4 CLK keeps well clear of the 3 CLK minimum
    task automatic xfer(input logic rd, input logic [5:0] addr,
                        input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {rd, 1'b0, addr, wdata};
        rdata = 16'h0;
        @(posedge clk);
        ce_n <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            mosi <= frame[23 - i];
            repeat (4) @(posedge clk);
            // data bits sampled just before each rise
            if (i >= 8) rdata = {rdata[14:0], miso};
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        // enable held past the write landing
        repeat (4) @(posedge clk);
        ce_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ===== testbench/imsc_top_monitor.sv
// concurrent checks on the interrupt and sequence control ports
// assumes it is bound into imsc_top; events are one-cycle pulses
module imsc_top_monitor (
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       CE_N,
    input wire logic       IRQ_N,
    input wire logic       RADIO_SEQUENCE_ENABLE_PIN,
    input wire logic       ATTN_N,
    input wire logic       COMPARATOR_TWO,
    input wire logic       COMPARATOR_TWO_PRIMED,
    input wire logic       COMPARATOR_ONE,
    input wire logic       EV_RAM_ADDR_ERR,
    input wire logic       EV_ARB_BUSY_ERR,
    input wire logic       EV_PLL_UNLOCK,
    input wire logic       EV_DOZE_TIMER,
    input wire logic       EV_ASSESS_DONE,
    input wire logic       EV_TX_DONE,
    input wire logic       EV_RX_DONE,
    input wire logic       SEQ_START,
    input wire logic [1:0] SEQ_SELECT,
    input wire logic       DOZE_ACTIVE,
    input wire logic       EVENT_TIMER_CLK_EN
);
    timeunit 1ns;
    timeprecision 1ns;

    wire logic  ev_any;   // any flag source or attention low
    wire logic  trig_any; // any sequence trigger
    logic [3:0] quiet;    // cycles since an event or a frame
    logic [3:0] ce_age;   // cycles since enable was low
    logic [3:0] trig_age; // cycles since a trigger

    assign ev_any = COMPARATOR_ONE | COMPARATOR_TWO | EV_RAM_ADDR_ERR
        | EV_ARB_BUSY_ERR | EV_PLL_UNLOCK | EV_DOZE_TIMER | EV_ASSESS_DONE
        | EV_TX_DONE | EV_RX_DONE | !ATTN_N;
    assign trig_any = RADIO_SEQUENCE_ENABLE_PIN | COMPARATOR_TWO
        | COMPARATOR_TWO_PRIMED;

    // saturating ages; reset to zero so no check fires at release
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            quiet    <= 4'h0;
            ce_age   <= 4'h0;
            trig_age <= 4'h0;
        end else begin
            quiet    <= (ev_any || !CE_N) ? 4'h0
                        : quiet + {3'h0, quiet != 4'hf};
            ce_age   <= !CE_N ? 4'h0 : ce_age + {3'h0, ce_age != 4'hf};
            trig_age <= trig_any ? 4'h0
                        : trig_age + {3'h0, trig_age != 4'hf};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // ****************************
    // interrupt pin and sequence start
    // ****************************
    irq_cause_a: assert property ($fell(IRQ_N) |-> quiet < 4'h4)
        else $error("interrupt asserted with no recent cause");
    irq_clear_a: assert property ($rose(IRQ_N) |-> ce_age < 4'h4)
        else $error("interrupt released outside a host access");
    start_sel_a: assert property (
        SEQ_START |-> $past(SEQ_SELECT) != 2'h0)
        else $error("sequence started while idle selected");
    start_cause_a: assert property (
        SEQ_START |-> trig_age < 4'h3)
        else $error("sequence started with no trigger");
    // ****************************
    // doze exits and timer clock gating
    // ****************************
    attn_wake_a: assert property (
        DOZE_ACTIVE && $fell(ATTN_N) |-> ##[1:2] !DOZE_ACTIVE)
        else $error("attention did not end doze");
    cmp_wake_a: assert property (
        DOZE_ACTIVE && $past(DOZE_ACTIVE, 2) && EVENT_TIMER_CLK_EN
        && COMPARATOR_TWO |-> ##[1:2] !DOZE_ACTIVE)
        else $error("comparator two did not end normal doze");
    deep_hold_a: assert property (
        DOZE_ACTIVE && !EVENT_TIMER_CLK_EN && ATTN_N && $past(ATTN_N)
        |=> DOZE_ACTIVE)
        else $error("deep doze left without attention");
    timer_gate_a: assert property (!DOZE_ACTIVE |=> EVENT_TIMER_CLK_EN)
        else $error("timer clock stopped outside doze");

    cover property ($fell(IRQ_N));
    cover property (SEQ_START);
    cover property (DOZE_ACTIVE && !EVENT_TIMER_CLK_EN);
endmodule

bind imsc_top imsc_top_monitor mon_u (.CLK(CLK), .ARST_N(ARST_N),
    .CE_N(CE_N), .IRQ_N(IRQ_N), .ATTN_N(ATTN_N),
    .RADIO_SEQUENCE_ENABLE_PIN(RADIO_SEQUENCE_ENABLE_PIN),
    .COMPARATOR_TWO(COMPARATOR_TWO), .COMPARATOR_ONE(COMPARATOR_ONE),
    .COMPARATOR_TWO_PRIMED(COMPARATOR_TWO_PRIMED),
    .EV_RAM_ADDR_ERR(EV_RAM_ADDR_ERR), .EV_ARB_BUSY_ERR(EV_ARB_BUSY_ERR),
    .EV_PLL_UNLOCK(EV_PLL_UNLOCK), .EV_DOZE_TIMER(EV_DOZE_TIMER),
    .EV_ASSESS_DONE(EV_ASSESS_DONE), .EV_TX_DONE(EV_TX_DONE),
    .EV_RX_DONE(EV_RX_DONE), .SEQ_START(SEQ_START),
    .SEQ_SELECT(SEQ_SELECT), .DOZE_ACTIVE(DOZE_ACTIVE),
    .EVENT_TIMER_CLK_EN(EVENT_TIMER_CLK_EN));

// ===== testbench/tb_irq_mask_and_sequence_control.sv
// self-checking bench for the mask and sequence control block
// assumes the host model; events come from pulse
module tb_irq_mask_and_sequence_control;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        arst_n;
    logic        doze_req;
    logic [15:0] pulse;   // one-cycle sources in status layout
    logic [15:0] rv;      // last word read back
    wire logic   ce_n, sclk, mosi, miso, irq_n, seq_start, miso_oe;
    wire logic   doze_active, tmr_clk_en;
    wire logic [1:0] seq_select, assess_type;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          starts = 0;  // sequence start pulses seen
    int          cyc = 0;     // cycles since time zero
    int          st[10] = '{15, 12, 11, 9, 4, 1, 0, 10, 7, 8};
    int          eb[10] = '{15, 12, 11, 9, 4, 1, 0, 10, 9, 8};

    imsc_top dut_u (.CLK(clk), .ARST_N(arst_n), .CE_N(ce_n), .SCLK(sclk),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .IRQ_N(irq_n),
        .RADIO_SEQUENCE_ENABLE_PIN(pulse[13]), .ATTN_N(~pulse[15]),
        .COMPARATOR_TWO(pulse[1]), .COMPARATOR_TWO_PRIMED(pulse[14]),
        .COMPARATOR_ONE(pulse[0]), .DOZE_REQUEST(doze_req),
        .EV_RAM_ADDR_ERR(pulse[12]), .EV_ARB_BUSY_ERR(pulse[11]),
        .EV_PLL_UNLOCK(pulse[9]), .EV_DOZE_TIMER(pulse[4]),
        .EV_ASSESS_DONE(pulse[10]), .EV_TX_DONE(pulse[7]),
        .EV_RX_DONE(pulse[8]), .SEQ_START(seq_start),
        .SEQ_SELECT(seq_select), .ASSESS_TYPE(assess_type),
        .DOZE_ACTIVE(doze_active), .EVENT_TIMER_CLK_EN(tmr_clk_en));

    imsc_host_model host_u (.clk(clk), .ce_n(ce_n), .sclk(sclk),
        .mosi(mosi), .miso(miso));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************
    // helpers
    // ****************************
    task wrap_up();
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    // pin is active low: an enabled source pulls it down
    task chk_irq(input int en);
        chk({15'h0, irq_n}, {15'h0, en == 0});
    endtask

    task wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host_u.xfer(1'b0, a, d, unused);
    endtask

    task rd(input logic [5:0] a, output logic [15:0] d);
        host_u.xfer(1'b1, a, 16'h0, d);
    endtask

    // one-cycle pulse on one source, then settle
    task ev(input int s);
        @(posedge clk);
        pulse <= 16'h1 << s;
        @(posedge clk);
        pulse <= 16'h0;
        repeat (4) @(posedge clk);
    endtask

    // doze entry needs a fresh rise of the request level
    task doze_on();
        @(posedge clk);
        doze_req <= 1'b0;
        @(posedge clk);
        doze_req <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // start counter and hang guard; the run needs about 16k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (seq_start === 1'b1)
            starts <= starts + 1;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ****************************
    // main sequence
    // ****************************
    initial begin
        int          i;
        int          k;
        int          en;
        logic [15:0] m;
        arst_n = 1'b0;
        doze_req = 1'b0;
        pulse = 16'h0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // reset values, reserved bits, unmapped address
        rd(6'h05, rv);
        chk(rv, 16'h8000);
        rd(6'h06, rv);
        chk(rv, 16'h0000);
        wr(6'h05, 16'hffff);
        rd(6'h05, rv);
        chk(rv, 16'h9b13);
        wr(6'h06, 16'hffff);
        rd(6'h06, rv);
        chk(rv, 16'h07b3);
        wr(6'h10, 16'hffff);
        rd(6'h10, rv);
        chk(rv, 16'h0000);
        rd(6'h3e, rv);
        // each source alone enabled, then all others
        for (en = 1; en >= 0; en--) begin
            for (i = 0; i < 10; i++) begin
                m = 16'h1 << eb[i];
                wr(6'h05, i < 7 ? (en ? m : 16'h9b13 & ~m)
                                : (en ? 16'h0 : 16'h9b13));
                wr(6'h06, i < 7 ? (en ? 16'h0 : 16'h0700)
                                : (en ? m : 16'h0700 & ~m));
                ev(st[i]);
                if (i < 7) chk_irq(en);
                else chk_irq(en);
                rd(6'h3e, rv);
                chk(rv, 16'h1 << st[i]);
                repeat (2) @(posedge clk);
                chk({14'h0, miso_oe, irq_n}, 16'h1);
            end
        end
        // every sequence and type code, manual then timer start
        for (k = 0; k < 4; k++) begin
            wr(6'h06, 16'(k * 17));
            chk({12'h0, seq_select, assess_type}, 16'(k * 5));
            i = starts;
            ev(13);
            ev(1);
            chk(16'(starts - i), 16'(k != 0));
            wr(6'h06, 16'(k * 17 + 128));
            ev(1);
            ev(14);
            ev(13);
            chk(16'(starts - i), 16'(k != 0 ? 3 : 0));
        end
        // normal doze: comparator and attention both wake
        wr(6'h06, 16'h0000);
        wr(6'h05, 16'h0000);
        doze_on();
        chk({15'h0, doze_active}, 16'h1);
        ev(1);
        chk({15'h0, doze_active}, 16'h0);
        doze_on();
        ev(15);
        chk({15'h0, doze_active}, 16'h0);
        // deep doze: timers stop, only attention wakes
        wr(6'h05, 16'h0100);
        doze_on();
        chk({14'h0, doze_active, tmr_clk_en}, 16'h2);
        ev(1);
        chk({14'h0, doze_active, tmr_clk_en}, 16'h2);
        ev(15);
        chk({14'h0, doze_active, tmr_clk_en}, 16'h1);
        wrap_up();
    end
endmodule
